// ==== logic/nfc_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module nfc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clock, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // read data, registered
  output logic out_valid, // data available
  input wire logic out_ready // consumer takes data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [WIDTH-1:0] out_reg, out_next;
  logic ov_reg, ov_next;
  logic push, pop_mem, mem_empty;
  logic [AW:0] used, fill;

  assign mem_empty = (wr_reg == rd_reg);
  assign used = wr_reg - rd_reg;
  // the output register counts as a slot, so DEPTH words fill the fifo, not DEPTH+1
  assign fill = used + {{AW{1'b0}}, ov_reg};
  assign in_ready = (fill < (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // output register refills whenever it is empty or being taken
  assign pop_mem = !mem_empty && (!ov_reg || out_ready);
  assign out_data = out_reg;
  assign out_valid = ov_reg;

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop_mem ? rd_reg + 1'b1 : rd_reg;
    out_next = pop_mem ? mem[rd_reg[AW-1:0]] : out_reg;
    ov_next = pop_mem ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      out_reg <= '0;
      ov_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      out_reg <= out_next;
      ov_reg <= ov_next;
    end
  end
endmodule : nfc_fifo
`default_nettype wire

// ==== logic/nfc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module nfc_host #(
  parameter int unsigned BUSY_TIMEOUT = nfc_pkg::BUSY_TIMEOUT_CYCLES
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic reset_n, // async reset, active low
  input wire nfc_pkg::nfc_req_s req, // bus cycle request
  input wire logic req_valid, // request offered
  output logic req_ready, // request taken this cycle
  input wire logic wait_ready, // hold request until device ready
  input wire logic write_protect, // 1 protects array
  input wire logic standby, // release chip select when idle
  output logic [7:0] rd_data, // read byte from fifo
  output logic rd_valid, // read byte available
  input wire logic rd_ready, // consumer takes read byte
  output logic dev_busy, // synchronised busy level
  output logic timeout, // busy exceeded limit, sticky until reset
  output logic [7:0] io_out, // byte bus drive value
  output logic io_oe, // byte bus drive enable
  input wire logic [7:0] io_in, // byte bus sampled value
  output nfc_pkg::nfc_ctl_s ctl, // chip select, selects and strobes
  output logic write_protect_n, // write-protect pin, low protects
  input wire logic ready_busy_in // open-drain ready/busy, pulled up
);
  typedef enum logic [2:0] {NFC_IDLE, NFC_SETUP, NFC_LOW, NFC_HIGH, NFC_SAMPLE} nfc_state_e;

  nfc_state_e state_reg, state_next;
  nfc_pkg::nfc_req_s cur_reg, cur_next;
  nfc_pkg::nfc_ctl_s ctl_reg, ctl_next;
  logic [7:0] io_reg, io_next;
  logic oe_reg, oe_next;
  logic [2:0] addr_cnt_reg, addr_cnt_next;
  logic [31:0] busy_cnt_reg, busy_cnt_next;
  logic to_reg, to_next;
  logic [3:0] wait_reg, wait_next;
  logic rb_meta_reg, rb_sync_reg;
  logic [7:0] io_meta_reg, io_sync_reg;
  logic [7:0] fifo_din;
  logic fifo_push, fifo_in_ready;
  logic is_read;

  // open-drain ready/busy: low is busy
  assign dev_busy = !rb_sync_reg;
  assign timeout = to_reg;
  assign ctl = ctl_reg;
  assign io_out = io_reg;
  assign io_oe = oe_reg;
  // continuous level, never strobed
  assign write_protect_n = !write_protect;
  assign is_read = (req.op == nfc_pkg::NFC_OP_READ);
  // a read is only taken when fifo space exists, so back-pressure reaches the requester
  assign req_ready = (state_reg == NFC_IDLE) && req_valid && !(wait_ready && dev_busy) &&
                     (!is_read || fifo_in_ready);

  nfc_fifo #(.WIDTH(8), .DEPTH(nfc_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_data(fifo_din),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );

  assign fifo_din = io_sync_reg;
  assign fifo_push = (state_reg == NFC_SAMPLE) && (wait_reg == 4'h0);

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    ctl_next = ctl_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    addr_cnt_next = addr_cnt_reg;
    wait_next = (wait_reg != 4'h0) ? wait_reg - 4'h1 : 4'h0;
    case (state_reg)
      NFC_IDLE: begin
        ctl_next.we_n = 1'b1;
        ctl_next.output_strobe_n = 1'b1;
        ctl_next.cle = 1'b0;
        ctl_next.ale = 1'b0;
        oe_next = 1'b0;
        // chip select may rise only when idle; device ignores it while busy
        if (standby && !req_valid) begin
          ctl_next.ce_n = 1'b1;
        end
        if (req_ready) begin
          cur_next = req;
          ctl_next.ce_n = 1'b0;
          // selects are mutually exclusive by construction
          ctl_next.cle = (req.op == nfc_pkg::NFC_OP_CMD);
          ctl_next.ale = (req.op == nfc_pkg::NFC_OP_ADDR);
          if (req.op == nfc_pkg::NFC_OP_CMD) begin
            addr_cnt_next = 3'h0;
          end
          io_next = req.data;
          if (req.op == nfc_pkg::NFC_OP_ADDR) begin
            // unused high bits forced low
            if (addr_cnt_reg == 3'h1) begin
              io_next = req.data & nfc_pkg::COL_HI_MASK;
            end else if (addr_cnt_reg == 3'h4) begin
              io_next = req.data & nfc_pkg::BLK_HI_MASK;
            end
            if (addr_cnt_reg < 3'(nfc_pkg::ADDR_BYTES_MAX)) begin
              addr_cnt_next = addr_cnt_reg + 3'h1;
            end
          end
          oe_next = !is_read;
          state_next = NFC_SETUP;
        end
      end
      NFC_SETUP: begin
        // one cycle of setup before the strobe falls
        if (cur_reg.op == nfc_pkg::NFC_OP_READ) begin
          ctl_next.output_strobe_n = 1'b0;
          wait_next = 4'(nfc_pkg::OUTPUT_VALID_DELAY_CYCLES + 2);
          state_next = NFC_SAMPLE;
        end else begin
          ctl_next.we_n = 1'b0;
          state_next = NFC_LOW;
        end
      end
      NFC_LOW: begin
        // rising edge latches the byte; data stays driven one more cycle for hold
        ctl_next.we_n = 1'b1;
        state_next = NFC_HIGH;
      end
      NFC_HIGH: begin
        ctl_next.cle = 1'b0;
        ctl_next.ale = 1'b0;
        oe_next = 1'b0;
        state_next = NFC_IDLE;
      end
      NFC_SAMPLE: begin
        // wait covers output-valid delay plus the two synchroniser stages
        if (wait_reg == 4'h0) begin
          ctl_next.output_strobe_n = 1'b1;
          state_next = NFC_IDLE;
        end
      end
      default: begin
        state_next = NFC_IDLE;
      end
    endcase
  end

  always_comb begin
    busy_cnt_next = dev_busy ? busy_cnt_reg + 32'h1 : 32'h0;
    to_next = to_reg || (dev_busy && (busy_cnt_reg >= 32'(BUSY_TIMEOUT)));
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= NFC_IDLE;
      cur_reg <= '0;
      ctl_reg <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1};
      io_reg <= 8'h00;
      oe_reg <= 1'b0;
      addr_cnt_reg <= 3'h0;
      wait_reg <= 4'h0;
      busy_cnt_reg <= 32'h0;
      to_reg <= 1'b0;
      rb_meta_reg <= 1'b0;
      rb_sync_reg <= 1'b0;
      io_meta_reg <= 8'h00;
      io_sync_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      ctl_reg <= ctl_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      addr_cnt_reg <= addr_cnt_next;
      wait_reg <= wait_next;
      busy_cnt_reg <= busy_cnt_next;
      to_reg <= to_next;
      rb_meta_reg <= ready_busy_in;
      rb_sync_reg <= rb_meta_reg;
      io_meta_reg <= io_in;
      io_sync_reg <= io_meta_reg;
    end
  end
endmodule : nfc_host
`default_nettype wire

// ==== logic/nfc_pkg.sv ====
// Operation
// - one shared byte bus carries command, address and data in separate cycles
// - command-select high qualifies a command byte latched on write strobe rise
// - address-select high qualifies an address byte latched on write strobe rise
// - write strobe rising edge latches bytes; bus held stable across it
// - ready/busy is open drain; pulled up, low means busy
// - five address bytes: column, page, plane, block; unused bits low
package nfc_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned PLANES = 2;
  localparam int unsigned BLOCKS_PER_PLANE = 1024;
  localparam int unsigned PAGES_PER_BLOCK = 256;
  localparam int unsigned PAGE_MAIN_BYTES = 8192;
  localparam int unsigned PAGE_SPARE_BYTES = 640;
  localparam int unsigned PAGE_BYTES = PAGE_MAIN_BYTES + PAGE_SPARE_BYTES;
  localparam int unsigned PROG_TIME_US = 1300;
  localparam int unsigned ERASE_TIME_US = 3500;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned BUSY_TIMEOUT_CYCLES = 4 * ERASE_CYCLES;
  localparam int unsigned STROBE_LOW_CYCLES = 1;
  localparam int unsigned STROBE_HIGH_CYCLES = 1;
  localparam int unsigned OUTPUT_VALID_DELAY_NS = 40;
  localparam int unsigned OUTPUT_VALID_DELAY_CYCLES = (OUTPUT_VALID_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned ADDR_BYTES_MAX = 5;
  localparam logic [7:0] COL_HI_MASK = 8'h3f;
  localparam logic [7:0] BLK_HI_MASK = 8'h07;

  typedef enum logic [1:0] {NFC_OP_CMD, NFC_OP_ADDR, NFC_OP_WRITE, NFC_OP_READ} nfc_op_e;

  typedef struct packed {
    nfc_op_e op;
    logic [7:0] data;
  } nfc_req_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
  } nfc_ctl_s;
endpackage : nfc_pkg

// ==== verification/nfc_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module nfc_flash_model #(
  parameter int unsigned PROG_BUSY = 60, // shortened program time
  parameter int unsigned ERASE_BUSY = 300 // shortened erase time
) (
  input wire logic clock, // clock
  input wire nfc_pkg::nfc_ctl_s ctl, // pin controls
  input wire logic [7:0] io_bus, // resolved bus level
  input wire logic io_oe, // host drives bus
  input wire logic write_protect_n, // low protects
  output logic [7:0] io_drive, // device drive value
  output logic ready_busy // pulled-up ready/busy line
);
  // 14 column bits reach every byte of the 8,832-byte page
  logic [13:0] col = 14'h0000;
  logic [7:0] abyte [5] = '{default: 8'h00};
  int unsigned acnt = 0;
  int unsigned busy_cnt = 0;
  initial io_drive = 8'h00;
  assign ready_busy = (busy_cnt == 0);
  always @(posedge clock) if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
  always @(posedge ctl.we_n) if (!ctl.ce_n) begin
    if (ctl.cle) begin
      acnt = 0;
      if (write_protect_n && io_bus == 8'h10) busy_cnt = PROG_BUSY;
      if (write_protect_n && io_bus == 8'hd0) busy_cnt = ERASE_BUSY;
    end else if (ctl.ale) begin
      if (acnt == 0) col[7:0] = io_bus;
      if (acnt == 1) col[13:8] = io_bus[5:0];
      // bytes 3 to 5 hold page (256 per block), plane bit and block (1,024 per plane)
      if (acnt < 5) abyte[acnt] = io_bus;
      if (acnt < 5) acnt++;
    end
  end
  always @(negedge ctl.output_strobe_n) if (!ctl.ce_n) begin
    io_drive <= #10 col[7:0] ^ 8'h3c;
    col++;
  end
  // released or disabled bus shows the inverse, except while busy with the host not driving, so a stale byte does not pass for data
  always @(posedge io_oe or posedge ctl.ce_n or posedge ctl.output_strobe_n)
    if (busy_cnt == 0 || io_oe) io_drive = ~io_drive;
endmodule : nfc_flash_model
`default_nettype wire

// ==== verification/nfc_host_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module nfc_host_props (
  input wire logic clock, // clock
  input wire logic reset_n, // reset, active low
  input wire logic write_protect, // protect request
  input wire logic [7:0] rd_data, // read byte
  input wire logic rd_valid, // read byte valid
  input wire logic rd_ready, // read byte taken
  input wire logic dev_busy, // busy level
  input wire logic timeout, // busy too long
  input wire logic [7:0] io_out, // bus drive value
  input wire logic io_oe, // bus drive enable
  input wire nfc_pkg::nfc_ctl_s ctl, // pin controls
  input wire logic write_protect_n, // protect pin
  input wire logic ready_busy_in // ready/busy pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_SELECTS: assert property (!(ctl.cle && ctl.ale))
    else $error("both selects high");
  AST_STROBES: assert property (!(!ctl.we_n && !ctl.output_strobe_n))
    else $error("both strobes low");
  AST_WE_RISE: assert property ($rose(ctl.we_n) |-> io_oe && $stable(io_out))
    else $error("bus not held at latch edge");
  AST_WE_FALL: assert property ($fell(ctl.we_n) |-> !ctl.ce_n && io_oe ##1 $rose(ctl.we_n))
    else $error("bad write strobe pulse");
  AST_RD_FLOAT: assert property (!ctl.output_strobe_n |-> !io_oe && !ctl.ce_n)
    else $error("host drives during read");
  AST_WP_PIN: assert property (write_protect_n == !write_protect)
    else $error("protect pin wrong");
  AST_BUSY_SYNC: assert property ($past(reset_n, 3) |-> dev_busy == !$past(ready_busy_in, 2))
    else $error("busy level wrong");
  AST_TO_CAUSE: assert property ($rose(timeout) |-> $past(dev_busy))
    else $error("timeout without busy");
  AST_TO_STICKY: assert property (timeout |=> timeout)
    else $error("timeout cleared");
  AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read byte dropped");
endmodule : nfc_host_props
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  nfc_pkg::nfc_req_s req = '0;
  logic req_valid = 1'b0, wait_ready = 1'b1, write_protect = 1'b0, standby = 1'b0, rd_ready = 1'b1;
  logic req_ready, rd_valid, dev_busy, timeout, io_oe, write_protect_n, ready_busy_in;
  logic [7:0] rd_data, io_out, dev_io, bus_io;
  nfc_pkg::nfc_ctl_s ctl;
  logic [7:0] exp_q[$];
  logic [13:0] col;
  int num_errors = 0, num_checks = 0, cnt;
  bit ok;
  assign bus_io = io_oe ? io_out : dev_io;
  nfc_host #(.BUSY_TIMEOUT(100)) uut (.clock(clock), .reset_n(reset_n), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .wait_ready(wait_ready),
    .write_protect(write_protect), .standby(standby), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .dev_busy(dev_busy), .timeout(timeout), .io_out(io_out), .io_oe(io_oe),
    .io_in(bus_io), .ctl(ctl), .write_protect_n(write_protect_n), .ready_busy_in(ready_busy_in));
  nfc_flash_model dev (.clock(clock), .ctl(ctl), .io_bus(bus_io), .io_oe(io_oe),
    .write_protect_n(write_protect_n), .io_drive(dev_io), .ready_busy(ready_busy_in));
  initial forever #20 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic try_req(input nfc_pkg::nfc_op_e op, input logic [7:0] d, input int lim);
    int n;
    n = 0;
    ok = 0;
    @(posedge clock);
    #2 req = '{op, d};
    req_valid = 1'b1;
    while (!ok && n < lim) begin
      @(negedge clock);
      ok = req_ready;
      n++;
      @(posedge clock);
      #2;
    end
    req_valid = 1'b0;
    if (ok && op == nfc_pkg::NFC_OP_READ) begin
      exp_q.push_back(col[7:0] ^ 8'h3c);
      col++;
    end
  endtask : try_req
  task automatic send(input nfc_pkg::nfc_op_e op, input logic [7:0] d);
    try_req(op, d, 2000);
    if (!ok) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : send
  task automatic cmd_addr(input logic [7:0] c, input int na);
    logic [7:0] b;
    send(nfc_pkg::NFC_OP_CMD, c);
    for (int i = 0; i < na; i++) begin
      b = 8'($urandom);
      send(nfc_pkg::NFC_OP_ADDR, b);
      if (i == 0) col[7:0] = b;
      if (i == 1) col[13:8] = b[5:0];
    end
  endtask : cmd_addr
  task automatic wait_dev();
    int n;
    n = 0;
    while (dev_busy !== 1'b0 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    if (dev_busy !== 1'b0) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_dev
  // random stalls on the consumer side while the fifo empties
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge clock);
      #2 rd_ready = 1'($urandom);
      n++;
    end
    @(posedge clock);
    #2 rd_ready = 1'b1;
    if (exp_q.size() != 0) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : drain
  always @(posedge clock) if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
    // a byte with nothing expected is a mismatch, even when it is unknown
    if (exp_q.size() == 0) check(8'h00, 8'h01);
    else check(rd_data, exp_q.pop_front());
  end
  initial begin
    void'($urandom(15941));
    repeat (10) @(posedge clock);
    #2 reset_n = 1'b1;
    cmd_addr(8'h80, 5);
    repeat (4) send(nfc_pkg::NFC_OP_WRITE, 8'($urandom));
    check(dev.abyte[1] & 8'hc0, 8'h00);
    check(dev.abyte[4] & 8'hf8, 8'h00);
    send(nfc_pkg::NFC_OP_CMD, 8'h10);
    repeat (6) @(posedge clock);
    #2 check(dev_busy, 8'h01);
    wait_dev();
    check(timeout, 8'h00);
    $display("program test done");
    cmd_addr(8'h00, 5);
    send(nfc_pkg::NFC_OP_CMD, 8'h30);
    repeat (8) send(nfc_pkg::NFC_OP_READ, 8'h00);
    drain();
    $display("read test done");
    @(posedge clock);
    #2 rd_ready = 1'b0;
    cnt = 0;
    repeat (40) begin
      try_req(nfc_pkg::NFC_OP_READ, 8'h00, 20);
      if (ok) cnt++;
    end
    check(8'(cnt), 8'h20);
    drain();
    $display("fifo test done");
    @(posedge clock);
    #2 write_protect = 1'b1;
    @(negedge clock);
    check(write_protect_n, 8'h00);
    cmd_addr(8'h80, 5);
    send(nfc_pkg::NFC_OP_CMD, 8'h10);
    repeat (6) @(posedge clock);
    #2 check(dev_busy, 8'h00);
    write_protect = 1'b0;
    standby = 1'b1;
    repeat (3) @(posedge clock);
    #2 check(ctl.ce_n, 8'h01);
    standby = 1'b0;
    $display("protect and standby test done");
    cmd_addr(8'h60, 3);
    send(nfc_pkg::NFC_OP_CMD, 8'hd0);
    repeat (6) @(posedge clock);
    #2 check(dev_busy, 8'h01);
    wait_dev();
    check(timeout, 8'h01);
    $display("erase test done");
    tally_and_finish();
  end
endmodule : testbench
bind nfc_host nfc_host_props chk (.clock(clock), .reset_n(reset_n),
  .write_protect(write_protect), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .dev_busy(dev_busy), .timeout(timeout), .io_out(io_out), .io_oe(io_oe), .ctl(ctl),
  .write_protect_n(write_protect_n), .ready_busy_in(ready_busy_in));
`default_nettype wire
